// [verilog/tpsw_pkg.sv]
// Shared constants and types of the text page store writer
package tpsw_pkg;

	// Text memory address is {block, row, column}
	localparam int         TPSW_AW        = 15;
	localparam int         TPSW_DW        = 8;
	localparam int         TPSW_PW        = 2;

	// Packet kinds announced by the front end
	localparam logic [2:0] PKT_HEADER     = 3'h0;
	localparam logic [2:0] PKT_ROW        = 3'h1;
	localparam logic [2:0] PKT_X24        = 3'h2;
	localparam logic [2:0] PKT_X27        = 3'h3;
	localparam logic [2:0] PKT_BSP        = 3'h4;

	// Block numbers
	localparam logic [3:0] INV_BLOCK      = 4'h8;
	localparam logic [3:0] EXT_BLOCK      = 4'h9;
	localparam logic [3:0] SINGLE_VPS_BLK = 4'h0;

	// Row numbers
	localparam logic [4:0] HDR_ROW        = 5'h00;
	localparam logic [4:0] CTRL_ROW       = 5'h19;
	localparam logic [4:0] X24_ROW_SINGLE = 5'h18;
	localparam logic [4:0] EXT_ROW_OFS    = 5'h02;
	localparam logic [4:0] BSP_ROW_A      = 5'h02;
	localparam logic [4:0] BSP_ROW_B      = 5'h03;
	localparam logic [4:0] BSP_ROW_C      = 5'h14;
	localparam logic [4:0] SPT_ROW_BASE   = 5'h04;
	localparam logic [3:0] BSP_DESIG_B    = 4'h2;
	localparam logic [3:0] BSP_DESIG_C    = 4'h4;

	// Column and byte counts
	localparam logic [5:0] HDR_DEC_BYTES  = 6'h08;
	localparam logic [5:0] PKT_BYTES      = 6'h28;
	localparam logic [5:0] HDR_UNITS_COL  = 6'h00;
	localparam logic [5:0] HDR_TENS_COL   = 6'h01;
	localparam logic [5:0] HDR_C6_COL     = 6'h05;
	localparam logic [5:0] HDR_NAT_COL    = 6'h07;
	localparam int         HDR_C6_BIT     = 3;

	// VPS byte numbering and row 25 columns
	localparam logic [4:0] VPS_FIRST_BYTE = 5'h03;
	localparam logic [4:0] VPS_BYTE_4     = 5'h04;
	localparam logic [4:0] VPS_BYTE_5     = 5'h05;
	localparam logic [4:0] VPS_BYTE_11    = 5'h0B;
	localparam logic [4:0] VPS_LAST_BYTE  = 5'h0F;
	localparam logic [5:0] VPS_COL_B4     = 6'h14;
	localparam logic [5:0] VPS_COL_B5     = 6'h16;
	localparam logic [5:0] VPS_COL_B11    = 6'h0A;

	// Substituted character entries
	localparam logic [4:0] SUB_MODE_CHAR  = 5'h0F;
	localparam logic [6:0] SUB_CHAR_MIN   = 7'h20;

	// Write engine states
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PCHK = 3'b001,
		S_TWR  = 3'b010,
		S_SRD  = 3'b011,
		S_SWR  = 3'b100
	} tpsw_state_t;

	// Kinds of queued memory job
	typedef enum logic [1:0] {
		J_PLAIN = 2'b00,
		J_GUARD = 2'b01,
		J_SUB   = 2'b10,
		J_INV   = 2'b11
	} tpsw_job_t;

endpackage

// [verilog/tpsw_mem.sv]
// Dual-port text memory with registered read data
`timescale 1ns/10ps
module tpsw_mem #(
	parameter int WIDTH = 8,
	parameter int AW    = 15
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             a_en,
	input  wire logic             a_we,
	input  wire logic [AW-1:0]    a_addr,
	input  wire logic [WIDTH-1:0] a_wdata,
	output logic      [WIDTH-1:0] a_q,
	input  wire logic             b_en,
	input  wire logic             b_we,
	input  wire logic [AW-1:0]    b_addr,
	input  wire logic [WIDTH-1:0] b_wdata,
	output logic      [WIDTH-1:0] b_q
);
	// Starts cleared: stale protection bits would block page writes
	logic [WIDTH-1:0] mem [0:(1<<AW)-1] = '{default: '0};

	if (WIDTH < 1 || AW < 1 || AW > 20) begin : g_chk
		$error("tpsw_mem: unsupported width or depth");
	end

	// Port A written last so acquisition wins a same-address clash
	always_ff @(posedge clk) begin
		if (b_en && b_we)
			mem[b_addr] <= b_wdata;
		if (a_en && a_we)
			mem[a_addr] <= a_wdata;
	end

	// Read registers, cleared so outputs are defined from reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			a_q <= '0;
			b_q <= '0;
		end else begin
			if (a_en)
				a_q <= mem[a_addr];
			if (b_en)
				b_q <= mem[b_addr];
		end
	end
endmodule // tpsw_mem

// [verilog/tpsw_ham84.sv]
// Hamming 8/4 byte decoder with single-error correction
`timescale 1ns/10ps
module tpsw_ham84 (
	input  wire logic [7:0] byte_in,
	output logic      [3:0] nib,
	output logic            err
);
	logic [2:0] syn;
	logic       par_bad;
	logic [3:0] fix;

	// Failing checks give a one; odd overall parity is correct
	always_comb begin
		syn[2] = ~(byte_in[0] ^ byte_in[1] ^ byte_in[5] ^ byte_in[7]);
		syn[1] = ~(byte_in[1] ^ byte_in[2] ^ byte_in[3] ^ byte_in[7]);
		syn[0] = ~(byte_in[1] ^ byte_in[3] ^ byte_in[4] ^ byte_in[5]);
		par_bad = ~(^byte_in);
		case (syn)
			3'b111:  fix = 4'h1;
			3'b011:  fix = 4'h2;
			3'b101:  fix = 4'h4;
			3'b110:  fix = 4'h8;
			default: fix = 4'h0;
		endcase
		// Syndrome with good overall parity means two bits are bad
		err = (syn != 3'b000) && !par_bad;
		nib = {byte_in[7], byte_in[5], byte_in[3], byte_in[1]} ^
			(par_bad ? fix : 4'h0);
	end
endmodule // tpsw_ham84

// [verilog/tpsw_top.sv]
// Text memory writer: packet placement, inventory, substitution, VPS
`timescale 1ns/10ps
// Overview of operation
// - With inventory enabled, block 8 holds transmitted and subtitle tables.
// - Each table has one byte per page 00H-FFH, one bit per magazine.
// - A page header sets its magazine bit in the transmitted table.
// - A header with subtitle bit set also sets the subtitle table bit.
// - Each 40-byte row packet goes into the row chosen by its packet number.
// - First eight header bytes are Hamming decoded into row 25 columns 0-7.
// - Packet 26 characters present in the set are written to page memory.
// - Packet 26 locations are protected from later ordinary packet bytes.
// - Single-page build drops the protection when Spanish option is seen.
// - Spanish handling off when version bit is zero or disable bit set.
// - Packet 26 ignores extension-off; its own off bit stops it entirely.
// - A packet 26 write sets its flag; software clears it by writing zero.
// - Enabled VPS from line 16 goes to row 25 of block 0 or 9.
// - Line 16 content is detected as teletext or VPS automatically.
// - VPS byte: data nibble in bits 0-3, error in bit 4, zeros above.
// - Acquired VPS data sets its flag; software clears it by writing zero.
// - Row 25 columns 10-19 hold VPS bytes 11-15, 20-23 hold bytes 4, 5.
// - In a multi-page build, block 9 holds X/24 and X/27/0 pairs per block plus service rows.
// - A page goes into the block numbered by its page request.
// - Extension-off captures no extensions and block 9 stores a page.
// - Decoded header bytes carry a Hamming error flag in bit 4.
module tpsw_top #(
	parameter bit         MULTI_PAGE     = 1'b1,
	parameter logic [2:0] SPANISH_OPTION = 3'h1,
	parameter logic [7:0] VPS_START_CODE = 8'h5A
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          pkt_start,
	input  wire logic [2:0]                    pkt_type,
	input  wire logic [4:0]                    pkt_num,
	input  wire logic [3:0]                    pkt_desig,
	input  wire logic [3:0]                    pkt_block,
	input  wire logic [2:0]                    pkt_mag,
	input  wire logic                          byte_valid,
	input  wire logic [7:0]                    byte_data,
	input  wire logic                          sub_valid,
	input  wire logic [4:0]                    sub_row,
	input  wire logic [5:0]                    sub_col,
	input  wire logic [4:0]                    sub_mode,
	input  wire logic [6:0]                    sub_data,
	input  wire logic                          line16_start,
	input  wire logic [7:0]                    line16_code,
	input  wire logic                          inventory_enable,
	input  wire logic                          vps_capture_enable,
	input  wire logic                          extension_capture_off,
	input  wire logic                          char_substitution_off,
	input  wire logic                          spanish_handling_disable,
	input  wire logic                          rom_version_indicator,
	input  wire logic                          sub_flag_clear,
	input  wire logic                          vps_flag_clear,
	input  wire logic [tpsw_pkg::TPSW_AW-1:0]  mcu_addr,
	input  wire logic [tpsw_pkg::TPSW_DW-1:0]  mcu_wdata,
	input  wire logic                          mcu_wr,
	input  wire logic                          mcu_rd,
	output logic      [tpsw_pkg::TPSW_DW-1:0]  mcu_rdata,
	output logic                               substitution_written_flag,
	output logic                               vps_received_flag
);
	import tpsw_pkg::*;

	if (SPANISH_OPTION > 3'h7 || VPS_START_CODE > 8'hFF) begin : g_chk
		$error("tpsw_top: parameter out of range");
	end

	tpsw_state_t         state;
	tpsw_job_t           job_mode;
	tpsw_job_t           next_mode;
	logic                job_go, next_go;
	logic [TPSW_AW-1:0]  job_addr, next_addr;
	logic [7:0]          job_data, next_data;
	logic                job_vps_last, next_vps_last;
	logic [2:0]          cur_type, cur_mag;
	logic [4:0]          cur_num;
	logic [3:0]          cur_desig, cur_block;
	logic [5:0]          byte_idx;
	logic                in_vps;
	logic [4:0]          vps_idx;
	logic [9:0]          gen;
	logic [7:0]          page_num;
	logic                page_err, page_sub, spanish_seen, inv_pend;
	logic [3:0]          ham_nib;
	logic                ham_err;
	logic                a_en, a_we, p_en, p_we;
	logic [TPSW_AW-1:0]  a_addr;
	logic [7:0]          a_wdata, a_q;
	logic [1:0]          p_q;
	logic                spanish_active, prot_on, page_ok, prot_hit;
	logic                sub_set, vps_set;
	logic [7:0]          inv_mask;

	function automatic logic [TPSW_AW-1:0] mk_addr(input logic [3:0] blk,
		input logic [4:0] row, input logic [5:0] col);
		mk_addr = {blk, row, col};
	endfunction

	// Row in block 9 for an extension packet of block blk
	function automatic logic [4:0] ext_row(input logic [2:0] t,
		input logic [3:0] blk, input logic [3:0] dsg);
		logic [4:0] base;
		base = (blk == 4'h0) ? 5'h00 : ({blk, 1'b0} + EXT_ROW_OFS);
		if (t == PKT_X24)
			ext_row = base;
		else if (t == PKT_X27)
			ext_row = base + 5'h01;
		else if (dsg < BSP_DESIG_B)
			ext_row = BSP_ROW_A;
		else if (dsg < BSP_DESIG_C)
			ext_row = BSP_ROW_B;
		else
			ext_row = BSP_ROW_C;
	endfunction

	// Only characters the set holds are substituted
	function automatic logic char_ok(input logic [4:0] m,
		input logic [6:0] d);
		char_ok = (m == SUB_MODE_CHAR) && (d >= SUB_CHAR_MIN);
	endfunction

	tpsw_ham84 u_ham (
		.byte_in (byte_data),
		.nib     (ham_nib),
		.err     (ham_err)
	);

	// Spanish treatment gating and protection enable
	assign spanish_active = spanish_seen && rom_version_indicator &&
		!spanish_handling_disable;
	assign prot_on = MULTI_PAGE || !spanish_active;
	// Block 8 belongs to the inventory when enabled; block 9 to extensions in multi-page builds unless off
	assign page_ok = !(inventory_enable && cur_block == INV_BLOCK) &&
		!(MULTI_PAGE && !extension_capture_off &&
		cur_block == EXT_BLOCK);
	assign inv_mask = 8'(8'h01 << cur_mag);

	// Packet context, restarted by each packet announcement
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur_type <= PKT_ROW;
			cur_num <= 5'h00;
			cur_desig <= 4'h0;
			cur_block <= 4'h0;
			cur_mag <= 3'h0;
			byte_idx <= PKT_BYTES;
		end else if (pkt_start) begin
			cur_type <= pkt_type;
			cur_num <= pkt_num;
			cur_desig <= pkt_desig;
			cur_block <= pkt_block;
			cur_mag <= pkt_mag;
			byte_idx <= 6'h00;
		end else if (byte_valid && !in_vps && byte_idx < PKT_BYTES) begin
			byte_idx <= byte_idx + 6'h01;
		end
	end

	// Line 16: VPS start code selects VPS when VPS capture is enabled, anything else is teletext
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_vps <= 1'b0;
			vps_idx <= 5'h00;
		end else if (line16_start) begin
			in_vps <= vps_capture_enable &&
				line16_code == VPS_START_CODE;
			vps_idx <= 5'h00;
		end else if (pkt_start || (byte_valid && next_vps_last)) begin
			in_vps <= 1'b0;
		end else if (byte_valid && in_vps) begin
			vps_idx <= vps_idx + 5'h01;
		end
	end

	// Header generation per block; a new header lifts old protection
	always_ff @(posedge clk) begin
		if (sys_rst)
			gen <= 10'h000;
		else if (pkt_start && pkt_type == PKT_HEADER && pkt_block < 4'hA)
			gen[pkt_block] <= ~gen[pkt_block];
	end

	// Decoded page address, subtitle and national bits of the header
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			page_num <= 8'h00;
			page_err <= 1'b0;
			page_sub <= 1'b0;
			spanish_seen <= 1'b0;
			inv_pend <= 1'b0;
		end else begin
			inv_pend <= 1'b0;
			if (pkt_start && pkt_type == PKT_HEADER)
				page_err <= 1'b0;
			if (byte_valid && !in_vps && cur_type == PKT_HEADER) begin
				if (byte_idx == HDR_UNITS_COL || byte_idx == HDR_TENS_COL)
					page_err <= page_err | ham_err;
				if (byte_idx == HDR_UNITS_COL)
					page_num[3:0] <= ham_nib;
				if (byte_idx == HDR_TENS_COL)
					page_num[7:4] <= ham_nib;
				if (byte_idx == HDR_C6_COL)
					page_sub <= ham_nib[HDR_C6_BIT] && !ham_err;
				if (byte_idx == HDR_NAT_COL) begin
					spanish_seen <= !ham_err &&
						ham_nib[3:1] == SPANISH_OPTION;
					inv_pend <= inventory_enable;
				end
			end
		end
	end

	// Turns one incoming byte or substitution entry into a memory job
	always_comb begin
		logic [4:0] vb;
		logic [4:0] ofs;
		logic [3:0] bp_nib;
		logic       bp_err;
		vb = VPS_FIRST_BYTE + {1'b0, vps_idx[4:1]};
		ofs = vb - VPS_BYTE_11;
		bp_nib = {byte_data[7], byte_data[5], byte_data[3], byte_data[1]};
		bp_err = (byte_data[7] == byte_data[6]) ||
			(byte_data[5] == byte_data[4]) ||
			(byte_data[3] == byte_data[2]) ||
			(byte_data[1] == byte_data[0]);
		next_go = 1'b0;
		next_mode = J_PLAIN;
		next_addr = '0;
		next_data = 8'h00;
		next_vps_last = 1'b0;
		if (byte_valid && in_vps) begin
			next_data = {3'h0, bp_err, bp_nib};
			next_vps_last = (vb == VPS_LAST_BYTE) && vps_idx[0];
			next_go = 1'b1;
			// Two nibble columns per VPS byte
			if (vb == VPS_BYTE_4)
				next_addr = mk_addr(MULTI_PAGE ? EXT_BLOCK : SINGLE_VPS_BLK,
					CTRL_ROW, VPS_COL_B4 + {5'h00, vps_idx[0]});
			else if (vb == VPS_BYTE_5)
				next_addr = mk_addr(MULTI_PAGE ? EXT_BLOCK : SINGLE_VPS_BLK,
					CTRL_ROW, VPS_COL_B5 + {5'h00, vps_idx[0]});
			else if (vb >= VPS_BYTE_11 && vb <= VPS_LAST_BYTE)
				next_addr = mk_addr(MULTI_PAGE ? EXT_BLOCK : SINGLE_VPS_BLK,
					CTRL_ROW, VPS_COL_B11 + {ofs, vps_idx[0]});
			else
				next_go = 1'b0;
		end else if (byte_valid && byte_idx < PKT_BYTES) begin
			case (cur_type)
				PKT_HEADER: begin
					if (byte_idx < HDR_DEC_BYTES) begin
						next_go = page_ok;
						next_addr = mk_addr(cur_block, CTRL_ROW, byte_idx);
						next_data = {3'h0, ham_err, ham_nib};
					end else begin
						next_go = page_ok && ^byte_data;
						next_addr = mk_addr(cur_block, HDR_ROW, byte_idx);
						next_data = {1'b0, byte_data[6:0]};
					end
				end
				PKT_ROW: begin
					next_go = page_ok && ^byte_data;
					next_mode = prot_on ? J_GUARD : J_PLAIN;
					next_addr = mk_addr(cur_block, cur_num, byte_idx);
					next_data = {1'b0, byte_data[6:0]};
				end
				PKT_X24, PKT_X27, PKT_BSP: begin
					next_data = byte_data;
					if (MULTI_PAGE) begin
						next_go = !extension_capture_off;
						next_addr = mk_addr(EXT_BLOCK,
							ext_row(cur_type, cur_block, cur_desig),
							byte_idx);
					end else begin
						next_go = (cur_type == PKT_X24) && page_ok &&
							!extension_capture_off;
						next_addr = mk_addr(cur_block, X24_ROW_SINGLE, byte_idx);
					end
				end
				default: next_go = 1'b0;
			endcase
		end else if (sub_valid && !char_substitution_off) begin
			next_go = char_ok(sub_mode, sub_data) && page_ok;
			next_mode = J_SUB;
			next_addr = mk_addr(cur_block, sub_row, sub_col);
			next_data = {1'b1, sub_data};
		end else if (inv_pend && !page_err) begin
			next_go = 1'b1;
			next_mode = J_INV;
			next_addr = mk_addr(INV_BLOCK, {3'h0, page_num[7:6]},
				page_num[5:0]);
		end
	end

	// Job register between decode and the write engine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			job_go <= 1'b0;
			job_mode <= J_PLAIN;
			job_addr <= '0;
			job_data <= 8'h00;
			job_vps_last <= 1'b0;
		end else begin
			job_go <= next_go;
			if (next_go) begin
				job_mode <= next_mode;
				job_addr <= next_addr;
				job_data <= next_data;
				job_vps_last <= next_vps_last;
			end
		end
	end

	// Write engine; jobs arriving while busy are dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE:
					if (job_go && job_mode == J_GUARD)
						state <= S_PCHK;
					else if (job_go && job_mode == J_INV)
						state <= S_TWR;
				S_PCHK: state <= S_IDLE;
				S_TWR: state <= page_sub ? S_SRD : S_IDLE;
				S_SRD: state <= S_SWR;
				S_SWR: state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	// Protected when written by substitution since this page's header
	assign prot_hit = p_q[1] && p_q[0] == gen[job_addr[14:11]];

	// Memory port A drive for each engine step
	always_comb begin
		a_en = 1'b0;
		a_we = 1'b0;
		a_addr = job_addr;
		a_wdata = job_data;
		p_en = 1'b0;
		p_we = 1'b0;
		case (state)
			S_IDLE: begin
				a_en = job_go && job_mode != J_GUARD;
				a_we = job_go && (job_mode == J_PLAIN || job_mode == J_SUB);
				p_en = job_go && (job_mode == J_GUARD || job_mode == J_SUB);
				p_we = job_go && job_mode == J_SUB;
			end
			S_PCHK: begin
				a_en = !prot_hit;
				a_we = !prot_hit;
			end
			S_TWR: begin
				a_en = 1'b1;
				a_we = 1'b1;
				a_wdata = a_q | inv_mask;
			end
			S_SRD: begin
				a_en = 1'b1;
				a_addr = job_addr | {4'h0, SPT_ROW_BASE, 6'h00};
			end
			S_SWR: begin
				a_en = 1'b1;
				a_we = 1'b1;
				a_addr = job_addr | {4'h0, SPT_ROW_BASE, 6'h00};
				a_wdata = a_q | inv_mask;
			end
			default: a_en = 1'b0;
		endcase
	end

	assign sub_set = state == S_IDLE && job_go && job_mode == J_SUB;
	assign vps_set = state == S_IDLE && job_go && job_mode == J_PLAIN &&
		job_vps_last;

	// Received flags; a set beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst)
			substitution_written_flag <= 1'b0;
		else if (sub_set)
			substitution_written_flag <= 1'b1;
		else if (sub_flag_clear)
			substitution_written_flag <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			vps_received_flag <= 1'b0;
		else if (vps_set)
			vps_received_flag <= 1'b1;
		else if (vps_flag_clear)
			vps_received_flag <= 1'b0;
	end

	tpsw_mem #(.WIDTH(TPSW_DW), .AW(TPSW_AW)) u_text (
		.clk     (clk),
		.sys_rst (sys_rst),
		.a_en    (a_en),
		.a_we    (a_we),
		.a_addr  (a_addr),
		.a_wdata (a_wdata),
		.a_q     (a_q),
		.b_en    (mcu_rd | mcu_wr),
		.b_we    (mcu_wr),
		.b_addr  (mcu_addr),
		.b_wdata (mcu_wdata),
		.b_q     (mcu_rdata)
	);

	// Protection store: {written by substitution, header generation}
	tpsw_mem #(.WIDTH(TPSW_PW), .AW(TPSW_AW)) u_prot (
		.clk     (clk),
		.sys_rst (sys_rst),
		.a_en    (p_en),
		.a_we    (p_we),
		.a_addr  (job_addr),
		.a_wdata ({1'b1, gen[job_addr[14:11]]}),
		.a_q     (p_q),
		.b_en    (1'b0),
		.b_we    (1'b0),
		.b_addr  ('0),
		.b_wdata (2'h0),
		.b_q     ()
	);

	property p_sub_flag;
		@(posedge clk) disable iff (sys_rst)
		sub_set |=> substitution_written_flag;
	endproperty
	a_sub_flag: assert property (p_sub_flag)
		else $error("substitution flag not set");

	property p_vps_flag;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && in_vps && next_vps_last) |=> ##1 vps_received_flag;
	endproperty
	a_vps_flag: assert property (p_vps_flag)
		else $error("vps flag not set after last byte");

	property p_flag_prio;
		@(posedge clk) disable iff (sys_rst)
		(vps_set && vps_flag_clear) |=> vps_received_flag;
	endproperty
	a_flag_prio: assert property (p_flag_prio)
		else $error("clear won over set");

	property p_sub_off;
		@(posedge clk) disable iff (sys_rst)
		(sub_valid && !byte_valid && char_substitution_off && !inv_pend)
		|=> !job_go;
	endproperty
	a_sub_off: assert property (p_sub_off)
		else $error("substitution ran while switched off");

	property p_guard;
		@(posedge clk) disable iff (sys_rst)
		(state == S_PCHK && prot_hit) |-> !a_we;
	endproperty
	a_guard: assert property (p_guard)
		else $error("protected location overwritten");

	property p_vps_fmt;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && in_vps && next_go) |=>
		job_data[7:5] == 3'h0 && job_addr[10:6] == CTRL_ROW;
	endproperty
	a_vps_fmt: assert property (p_vps_fmt)
		else $error("bad vps byte format or row");

	property p_inv;
		@(posedge clk) disable iff (sys_rst)
		(state == S_TWR) |-> a_we && a_addr[14:11] == INV_BLOCK &&
		a_wdata == (a_q | inv_mask) ##1 (state != S_TWR);
	endproperty
	a_inv: assert property (p_inv)
		else $error("inventory write wrong");

	property p_hdr;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && !in_vps && cur_type == PKT_HEADER &&
		byte_idx < HDR_DEC_BYTES && page_ok) |=>
		job_go && job_addr[10:6] == CTRL_ROW && job_data[4] == $past(ham_err);
	endproperty
	a_hdr: assert property (p_hdr)
		else $error("header byte not placed in row 25");

	property p_ext_off;
		@(posedge clk) disable iff (sys_rst)
		(byte_valid && !in_vps && extension_capture_off &&
		(cur_type == PKT_X27 || cur_type == PKT_BSP)) |=> !job_go;
	endproperty
	a_ext_off: assert property (p_ext_off)
		else $error("extension captured while off");

endmodule // tpsw_top

// [tb/tpsw_fe_model.sv]
// Front end model: packet, byte, packet 26 and line 16 events
`timescale 1ns/10ps
module tpsw_fe_model import tpsw_pkg::*; (
	input  wire logic       clk,
	output logic            pkt_start,
	output logic [2:0]      pkt_type,
	output logic [4:0]      pkt_num,
	output logic [3:0]      pkt_block,
	output logic [2:0]      pkt_mag,
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic            sub_valid,
	output logic [4:0]      sub_row,
	output logic [5:0]      sub_col,
	output logic [4:0]      sub_mode,
	output logic [6:0]      sub_data,
	output logic            line16_start,
	output logic [7:0]      line16_code
);
	// Quiet at time zero
	initial begin
		{pkt_start, pkt_type, pkt_num, pkt_block, pkt_mag} = '0;
		{byte_valid, byte_data, sub_valid, sub_row, sub_col} = '0;
		{sub_mode, sub_data, line16_start, line16_code} = '0;
	end
	// Stale byte inverted so it never passes for fresh data
	task automatic fin();
		@(posedge clk);
		{pkt_start, byte_valid, sub_valid, line16_start} <= 4'h0;
		byte_data <= ~byte_data;
		repeat (7) @(posedge clk); // Eight-cycle event spacing
	endtask
	task automatic pkt(input logic [2:0] t, input logic [4:0] n,
		input logic [3:0] b, input logic [2:0] m);
		{pkt_type, pkt_num, pkt_block, pkt_mag} <= {t, n, b, m};
		pkt_start <= 1'b1;
		fin();
	endtask
	task automatic byt(input logic [7:0] d);
		{byte_data, byte_valid} <= {d, 1'b1};
		fin();
	endtask
	task automatic sub(input logic [4:0] r, input logic [5:0] c,
		input logic [6:0] d);
		{sub_row, sub_col, sub_mode, sub_data} <= {r, c, SUB_MODE_CHAR, d};
		sub_valid <= 1'b1;
		fin();
	endtask
	task automatic l16(input logic [7:0] c);
		{line16_code, line16_start} <= {c, 1'b1};
		fin();
	endtask
endmodule // tpsw_fe_model

// [tb/tpsw_top_tb_top.sv]
// Bench of the text memory writer with the front end model
`timescale 1ns/10ps
module tpsw_top_tb_top;
	import tpsw_pkg::*;
	localparam logic [7:0] VSTART = 8'h5A; // Arbitrary start code
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  pkt_desig = 4'h0;
	// Block 8 is never a capture target here
	logic        inventory_enable = 1'b1;
	logic        vps_capture_enable = 1'b1;
	logic        extension_capture_off = 1'b0;
	logic        char_substitution_off = 1'b0;
	logic        spanish_handling_disable = 1'b1;
	logic        rom_version_indicator = 1'b0;
	logic        sub_flag_clear = 1'b0;
	logic        vps_flag_clear = 1'b0;
	logic        mcu_wr = 1'b0;
	logic        mcu_rd = 1'b0;
	logic [14:0] mcu_addr = 15'h0000;
	logic [7:0]  mcu_wdata = 8'h00;
	logic [7:0]  mcu_rdata, byte_data, line16_code;
	logic        substitution_written_flag, vps_received_flag;
	logic        pkt_start, byte_valid, sub_valid, line16_start;
	logic [2:0]  pkt_type, pkt_mag;
	logic [4:0]  pkt_num, sub_row, sub_mode;
	logic [3:0]  pkt_block;
	logic [5:0]  sub_col;
	logic [6:0]  sub_data;
	int          mismatches = 0;
	int          cmp_count = 0;
	tpsw_fe_model fe (.clk, .pkt_start, .pkt_type, .pkt_num, .pkt_block,
		.pkt_mag, .byte_valid, .byte_data, .sub_valid, .sub_row, .sub_col,
		.sub_mode, .sub_data, .line16_start, .line16_code);
	tpsw_top #(.MULTI_PAGE(1'b1), .VPS_START_CODE(VSTART)) dut (.clk,
		.sys_rst, .pkt_start, .pkt_type, .pkt_num, .pkt_desig, .pkt_block,
		.pkt_mag, .byte_valid, .byte_data, .sub_valid, .sub_row, .sub_col,
		.sub_mode, .sub_data, .line16_start, .line16_code,
		.inventory_enable, .vps_capture_enable, .extension_capture_off,
		.char_substitution_off, .spanish_handling_disable,
		.rom_version_indicator, .sub_flag_clear, .vps_flag_clear,
		.mcu_addr, .mcu_wdata, .mcu_wr, .mcu_rd, .mcu_rdata,
		.substitution_written_flag, .vps_received_flag);
	always #12.5 clk = ~clk;
	// Hamming 8/4 encoder: data on odd bits, checks made odd
	function automatic logic [7:0] ham(input logic [3:0] n);
		logic [7:0] b;
		b = {n[3], 1'b0, n[2], 1'b0, n[1], 1'b0, n[0], 1'b0};
		b[0] = ~(b[1] ^ b[5] ^ b[7]);
		b[2] = ~(b[1] ^ b[3] ^ b[7]);
		b[4] = ~(b[1] ^ b[3] ^ b[5]);
		b[6] = ~(^b);
		return b;
	endfunction
	function automatic logic [14:0] ad(input logic [3:0] b,
		input logic [4:0] r, input logic [5:0] c);
		return {b, r, c};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		{mcu_addr, mcu_wdata, mcu_wr} <= {a, d, 1'b1};
		@(posedge clk);
		mcu_wr <= 1'b0;
		@(posedge clk);
	endtask
	// Read data taken at the edge that ends the cycle after the strobe
	task automatic rdc(input logic [14:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hFF);
		{mcu_addr, mcu_rd} <= {a, 1'b1};
		@(posedge clk);
		mcu_rd <= 1'b0;
		@(posedge clk);
		chk(mcu_rdata & m, e);
	endtask
	// Header for page A5 magazine 3, subtitle bit, byte 2 double error
	task automatic t_header();
		logic [3:0] nib [8];
		nib = '{4'h5, 4'hA, 4'h1, 4'h2, 4'h3, 4'h8, 4'h0, 4'h0};
		wr(ad(INV_BLOCK, 5'd2, 6'h25), 8'h00);
		wr(ad(INV_BLOCK, 5'd6, 6'h25), 8'h00);
		fe.pkt(PKT_HEADER, 5'd0, 4'h1, 3'd3);
		for (int i = 0; i < 8; i++)
			fe.byt(ham(nib[i]) ^ ((i == 2) ? 8'h03 : 8'h00));
		for (int i = 0; i < 8; i++)
			if (i != 2)
				rdc(ad(4'h1, CTRL_ROW, 6'(i)), {4'h0, nib[i]});
		rdc(ad(4'h1, CTRL_ROW, 6'd2), 8'h10, 8'h10);
		rdc(ad(INV_BLOCK, 5'd2, 6'h25), 8'h08);
		rdc(ad(INV_BLOCK, 5'd6, 6'h25), 8'h08);
	endtask
	// Substituted char survives a later plain byte; off bit blocks it
	task automatic t_sub();
		fe.sub(5'd3, 6'd0, 7'h23);
		chk({7'h0, substitution_written_flag}, 8'h01);
		fe.pkt(PKT_ROW, 5'd3, 4'h1, 3'd3);
		fe.byt(8'hC1);
		fe.byt(8'hC2);
		rdc(ad(4'h1, 5'd3, 6'd0), 8'hA3);
		rdc(ad(4'h1, 5'd3, 6'd1), 8'h42);
		fe.pkt(PKT_X24, 5'd0, 4'h1, 3'd3);
		fe.byt(8'h5B);
		rdc(ad(EXT_BLOCK, 5'd4, 6'd0), 8'h5B);
		sub_flag_clear <= 1'b1;
		char_substitution_off <= 1'b1;
		@(posedge clk);
		sub_flag_clear <= 1'b0;
		fe.sub(5'd3, 6'd2, 7'h24);
		chk({7'h0, substitution_written_flag}, 8'h00);
		char_substitution_off <= 1'b0;
	endtask
	// VPS: chip pairs 1001 give 9, equal chips flag an error
	task automatic t_vps();
		fe.l16(VSTART);
		for (int j = 0; j < 26; j++)
			fork
				fe.byt((j == 16) ? 8'hFF : 8'h96);
				if (j == 25) begin
					@(posedge clk);
					vps_flag_clear <= 1'b1;
					@(posedge clk);
					vps_flag_clear <= 1'b0;
				end
			join
		chk({7'h0, vps_received_flag}, 8'h01);
		rdc(ad(EXT_BLOCK, CTRL_ROW, 6'd20), 8'h09);
		rdc(ad(EXT_BLOCK, CTRL_ROW, 6'd21), 8'h09);
		rdc(ad(EXT_BLOCK, CTRL_ROW, 6'd10), 8'h1F);
		vps_flag_clear <= 1'b1;
		vps_capture_enable <= 1'b0;
		@(posedge clk);
		vps_flag_clear <= 1'b0;
		fe.l16(VSTART);
		for (int j = 0; j < 26; j++)
			fe.byt(8'h96);
		chk({7'h0, vps_received_flag}, 8'h00);
	endtask
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk({6'h0, substitution_written_flag, vps_received_flag}, 8'h00);
		t_header();
		t_sub();
		t_vps();
		conclude();
	end
endmodule // tpsw_top_tb_top
